// ===== design/sram_ctrl_map.svh
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH

`define CLK_PERIOD_NS        8
`define ADDR_W               17
`define DATA_W               8
// Pin timing figures in ns or us, as printed.
`define WRITE_ADDR_SETUP_NS  7
`define WRITE_DATA_SETUP_NS  6
`define STROBE_TURNOFF_NS    5
`define READ_CYCLE_NS        10
`define ADDR_ACCESS_NS       10
`define OE_ACCESS_NS         5
`define POWER_UP_WAIT_US     100
// Cycle counts, least times rounded up.
`define CEIL_CYC(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC      `CEIL_CYC(`WRITE_ADDR_SETUP_NS)
`define TURNOFF_CYC          `CEIL_CYC(`STROBE_TURNOFF_NS)
`define READ_WAIT_CYC        `CEIL_CYC(`ADDR_ACCESS_NS)
`define POWER_UP_WAIT_CYC    `CEIL_CYC(`POWER_UP_WAIT_US * 1000)
`define CNT_W                16

`endif

// ===== design/sram_ctrl_pkg.sv
package sram_ctrl_pkg;
    `include "sram_ctrl_map.svh"

    typedef enum logic [6:0] {
        ST_POWER = 7'h01,
        ST_IDLE  = 7'h02,
        ST_RSET  = 7'h04,
        ST_RWAIT = 7'h08,
        ST_WOFF  = 7'h10,
        ST_WPUL  = 7'h20,
        ST_WEND  = 7'h40
    } ctrl_state_t;

    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef logic [`CNT_W-1:0]  count_t;

    typedef struct packed {
        ctrl_state_t state;
        count_t      count;
        addr_t       addr;
        data_t       wdata;
        data_t       rdata;
        logic        rvalid;
        logic        sel_n;
        logic        sel2;
        logic        oe_n;
        logic        we_n;
        logic        drive;
        logic [2:0]  rst_sync;
    } ctrl_regs_t;
endpackage

// ===== design/sram_ctrl.sv
// Overview of operation
// - Write only while both selects and strobe active.
// - Data timed against the edge ending write.
// - Address stable 7 ns before write end.
// - Address may change at write bounds.
// - Data valid 6 ns before write end.
// - Strobe write with enable low: 5+6 ns.
// - Never drive pins while memory drives.
// - Read data valid 10 ns; cycle 10 ns.
// - Wait 100 us after power before access.
// - Strobe stays high through every read.
// - Address valid no later than select.
`timescale 1ns/1ns
module sram_ctrl
    import sram_ctrl_pkg::*;
#(
    parameter int POWER_WAIT = `POWER_UP_WAIT_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 req_valid_in,
    input  wire logic                 req_write_in,
    input  wire sram_ctrl_pkg::addr_t req_addr_in,
    input  wire sram_ctrl_pkg::data_t req_wdata_in,
    output logic                      req_ready_out,
    output sram_ctrl_pkg::data_t      rd_data_out,
    output logic                      rd_valid_out,
    output sram_ctrl_pkg::addr_t      word_address_out,
    output logic                      primary_select_n_out,
    output logic                      secondary_select_out,
    output logic                      output_enable_n_out,
    output logic                      write_strobe_n_out,
    output sram_ctrl_pkg::data_t      data_pins_out,
    output logic                      data_pins_oe_out,
    input  wire sram_ctrl_pkg::data_t data_pins_in
);
    import sram_ctrl_pkg::*;

    ctrl_regs_t r, nxt;
    logic       rst_n;
    data_t      din_s1_r, din_s2_r, din_s3_r;

    // Reset release through two flops, kept outside the state struct.
    logic [1:0] arst_sync_r;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            arst_sync_r <= 2'h0;
        end else begin
            arst_sync_r <= {arst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = arst_sync_r[1];

    // Read data passes three flops; a change is taken once stages two and three agree.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            din_s3_r <= 8'h00;
        end else begin
            din_s1_r <= data_pins_in;
            din_s2_r <= din_s1_r;
            din_s3_r <= din_s2_r;
        end
    end

    function automatic count_t cyc(input int n);
        cyc = count_t'((n < 1) ? 1 : n);
    endfunction

    always_comb begin
        nxt          = r;
        nxt.rvalid   = 1'b0;
        nxt.rst_sync = 3'h0;
        if (r.count != '0) begin
            nxt.count = r.count - count_t'(1);
        end
        unique case (r.state)
            ST_POWER: begin
                if (r.count == '0) begin
                    nxt.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                nxt.sel_n = 1'b1;
                nxt.oe_n  = 1'b1;
                nxt.we_n  = 1'b1;
                if (req_valid_in) begin
                    // Address goes out with the primary select still inactive; it follows next cycle (secondary select stays active).
                    nxt.addr  = req_addr_in;
                    nxt.wdata = req_wdata_in;
                    nxt.state = req_write_in ? ST_WOFF : ST_RSET;
                end
            end
            ST_RSET: begin
                nxt.sel_n = 1'b0;
                nxt.oe_n  = 1'b0;
                nxt.count = cyc(`READ_WAIT_CYC + 3);
                nxt.state = ST_RWAIT;
            end
            ST_RWAIT: begin
                if (r.count == '0 && din_s2_r == din_s3_r) begin
                    nxt.rdata  = din_s3_r;
                    nxt.rvalid = 1'b1;
                    nxt.sel_n  = 1'b1;
                    nxt.oe_n   = 1'b1;
                    nxt.count  = cyc(`TURNOFF_CYC);
                    nxt.state  = ST_POWER;
                end
            end
            ST_WOFF: begin
                // Enable is raised first so the memory lets go of the pins.
                nxt.oe_n = 1'b1;
                if (r.count == '0) begin
                    nxt.sel_n = 1'b0;
                    nxt.we_n  = 1'b0;
                    nxt.drive = 1'b1;
                    nxt.count = cyc(`WRITE_PULSE_CYC);
                    nxt.state = ST_WPUL;
                end
            end
            ST_WPUL: begin
                if (r.count == count_t'(1)) begin
                    // Strobe and select rise together; set-up is timed to that edge.
                    nxt.we_n  = 1'b1;
                    nxt.sel_n = 1'b1;
                    nxt.state = ST_WEND;
                end
            end
            ST_WEND: begin
                nxt.drive = 1'b0;
                nxt.state = ST_IDLE;
            end
            default: begin
                nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            // The power-up wait is a constant, so it can load straight from reset.
            r.state    <= ST_POWER;
            r.count    <= count_t'(POWER_WAIT);
            r.addr     <= 17'h00000;
            r.wdata    <= 8'h00;
            r.rdata    <= 8'h00;
            r.rvalid   <= 1'b0;
            r.sel_n    <= 1'b1;
            r.sel2     <= 1'b1;
            r.oe_n     <= 1'b1;
            r.we_n     <= 1'b1;
            r.drive    <= 1'b0;
            r.rst_sync <= 3'h0;
        end else begin
            r <= nxt;
        end
    end

    assign req_ready_out        = (r.state == ST_IDLE);
    assign rd_data_out          = r.rdata;
    assign rd_valid_out         = r.rvalid;
    assign word_address_out     = r.addr;
    assign primary_select_n_out = r.sel_n;
    assign secondary_select_out = r.sel2;
    assign output_enable_n_out  = r.oe_n;
    assign write_strobe_n_out   = r.we_n;
    assign data_pins_out        = r.wdata;
    assign data_pins_oe_out     = r.drive;
endmodule

// ===== testbench/sram_ctrl_checker.sv
`timescale 1ns/1ns
module sram_ctrl_checker
    import sram_ctrl_pkg::*;
#(
    parameter int POWER_WAIT = 1
) (
    input wire logic                 clk_in,
    input wire logic                 arst_n_in,
    input wire logic                 req_ready_out,
    input wire sram_ctrl_pkg::addr_t word_address_out,
    input wire logic                 primary_select_n_out,
    input wire logic                 output_enable_n_out,
    input wire logic                 write_strobe_n_out,
    input wire sram_ctrl_pkg::data_t data_pins_out,
    input wire logic                 data_pins_oe_out
);
    logic [15:0] cnt_r;
    wire         sel = !primary_select_n_out;
    wire         rd = !output_enable_n_out;
    wire         wr = !write_strobe_n_out && sel;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // Saturates so a long run never wraps back below the wait.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) cnt_r <= 16'h0000;
        else if (cnt_r != 16'hffff) cnt_r <= cnt_r + 16'h0001;
    end
    chk_rd_strobe: assert property (rd |-> write_strobe_n_out)
        else $error("strobe low in read");
    chk_no_fight: assert property (data_pins_oe_out |-> !rd)
        else $error("drive in read");
    chk_wr_addr: assert property (wr |=> $stable(word_address_out))
        else $error("address moved");
    chk_wr_data: assert property (wr |=> $stable(data_pins_out) && data_pins_oe_out)
        else $error("data not held");
    chk_sel_addr: assert property ($rose(sel) |-> $stable(word_address_out))
        else $error("address late");
    chk_rd_len: assert property ($rose(rd) |-> (rd && sel)[*2])
        else $error("read too short");
    chk_turn_off: assert property ($rose(data_pins_oe_out) |-> $past(output_enable_n_out)
        && $past(output_enable_n_out, 2))
        else $error("no turn-off gap");
    chk_power_wait: assert property (req_ready_out |-> cnt_r >= 16'(POWER_WAIT))
        else $error("access too early");
    cov_write: cover property (wr);
    cov_read: cover property ($rose(rd));
    cov_rd_wr: cover property (rd ##[1:20] wr);
endmodule
bind sram_ctrl sram_ctrl_checker #(.POWER_WAIT(POWER_WAIT)) chk (.clk_in, .arst_n_in,
    .req_ready_out, .word_address_out, .primary_select_n_out, .output_enable_n_out,
    .write_strobe_n_out, .data_pins_out, .data_pins_oe_out);

// ===== testbench/sram_model.sv
`timescale 1ns/1ns
module sram_model
    import sram_ctrl_pkg::*;
#(
    parameter int ACC_NS = 5
) (
    input  wire sram_ctrl_pkg::addr_t addr_in,
    input  wire logic                 sel_n_in,
    input  wire logic                 sel2_in,
    input  wire logic                 oe_n_in,
    input  wire logic                 we_n_in,
    input  wire sram_ctrl_pkg::data_t wdata_in,
    output sram_ctrl_pkg::data_t      rdata_out
);
    data_t mem [addr_t];
    data_t last_r = 8'h00;
    wire   wr = !sel_n_in && sel2_in && !we_n_in;
    wire   rd = !sel_n_in && sel2_in && !oe_n_in && we_n_in;
    always @(negedge wr) mem[addr_in] = wdata_in;
    // Released pins show the inverse of the last byte, so stale data cannot pass as fresh.
    assign #(ACC_NS) rdata_out = rd ? mem[addr_in] : ~last_r;
    always @(rdata_out) if (rd) last_r = rdata_out;
endmodule

// ===== testbench/sram_ctrl_tb_top.sv
`timescale 1ns/1ns
module sram_ctrl_tb_top;
    import sram_ctrl_pkg::*;
    localparam int PW = 40;
    logic  clk_in = 1'b0;
    logic  arst_n_in = 1'b0;
    logic  req_valid_in = 1'b0;
    logic  req_write_in = 1'b0;
    addr_t req_addr_in = 17'h00000;
    data_t req_wdata_in = 8'h00;
    logic  req_ready_out, rd_valid_out, primary_select_n_out, secondary_select_out;
    logic  output_enable_n_out, write_strobe_n_out, data_pins_oe_out;
    addr_t word_address_out;
    data_t rd_data_out, data_pins_out, data_pins_in, pin_rd, q;
    int    err_total = 0;
    int    cmp_count = 0;
    always #4 clk_in = ~clk_in;
    assign data_pins_in = data_pins_oe_out ? data_pins_out : pin_rd;
    sram_ctrl #(.POWER_WAIT(PW)) dut (.clk_in, .arst_n_in, .req_valid_in, .req_write_in,
        .req_addr_in, .req_wdata_in, .req_ready_out, .rd_data_out, .rd_valid_out,
        .word_address_out, .primary_select_n_out, .secondary_select_out,
        .output_enable_n_out, .write_strobe_n_out, .data_pins_out, .data_pins_oe_out,
        .data_pins_in);
    sram_model far (.addr_in(word_address_out), .sel_n_in(primary_select_n_out),
        .sel2_in(secondary_select_out), .oe_n_in(output_enable_n_out),
        .we_n_in(write_strobe_n_out), .wdata_in(data_pins_in), .rdata_out(pin_rd));
    task automatic check(input string what, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Looks on the falling edge, where levels are settled for the next rising edge.
    task automatic wait_hi(input bit rdv, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while ((rdv ? rd_valid_out : req_ready_out) !== 1'b1 && n < lim);
        if ((rdv ? rd_valid_out : req_ready_out) !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask
    task automatic xfer(input logic w, input addr_t a, input data_t d);
        int n;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        wait_hi(1'b0, 20, n);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        if (!w) wait_hi(1'b1, 30, n);
        q = rd_data_out;
    endtask
    task automatic t_power();
        int n;
        wait_hi(1'b0, 200, n);
        check("ready delay", 8'(n >= PW), 8'h01);
    endtask
    task automatic t_rw();
        addr_t a[4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
        foreach (a[i]) xfer(1'b1, a[i], a[i][7:0] ^ 8'h5a);
        foreach (a[i]) begin
            xfer(1'b0, a[i], 8'h00);
            check("read data", q, a[i][7:0] ^ 8'h5a);
        end
        xfer(1'b1, 17'h1ffff, 8'ha5);
        xfer(1'b0, 17'h1ffff, 8'h00);
        check("rewrite", q, 8'ha5);
        check("second select", 8'(secondary_select_out), 8'h01);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_power();
        t_rw();
        final_report();
    end
endmodule
